/* File: logic/osio_top.sv */
// Purpose: origin sensor, encoder index, in-position and deviation clear io
// Assumes: classic Wishbone slave, 32-bit data, motion core gives events
// Notes: registers answer in one cycle, unmapped reads return zero
//
// Notes on behaviour
// - origin sampled at each output pulse rise
// - origin latch held, cleared at motor stop
// - origin and index active in homing modes
// - env1 bit 7 sets origin polarity
// - status bit 21 shows origin input
// - env2 bits 7..4 hold index count-1
// - env2 bit 3 picks counted index edge
// - status bit 7 shows index input
// - env2 bit 10 filters index under 3 cycles
// - mode bit 9 holds busy until in-position
// - busy pin and busy status change together
// - in-position already on ends at once
// - env1 bit 11 sets in-position polarity
// - status bit 22 shows in-position input
// - env1 bit 12 filters in-position under 4us
// - env1 bit 23 selects clear or current-reduction
// - env1 bit 24 clears on immediate stop
// - env1 bit 25 clears on home done
// - env1 bits 18..16 set clear width, 111 level
// - env1 bits 22..20 set off delay
// - env1 bit 19 clear polarity, status 23
// - commands 10h on, 11h off
`timescale 1ns/100ps
`include "osio_cfg.svh"
module osio_top
    import osio_pkg::*;
#(
    parameter int unsigned WIDTH_CYC [7] = '{
        `OSIO_US2CYC(`OSIO_W0_US), `OSIO_US2CYC(`OSIO_W1_US),
        `OSIO_US2CYC(`OSIO_W2_US), `OSIO_US2CYC(`OSIO_W3_US),
        `OSIO_US2CYC(`OSIO_W4_US), `OSIO_US2CYC(`OSIO_W5_US),
        `OSIO_US2CYC(`OSIO_W6_US)},
    parameter int unsigned DELAY_CYC [8] = '{0,
        `OSIO_US2CYC(`OSIO_D1_US), `OSIO_US2CYC(`OSIO_D2_US),
        `OSIO_US2CYC(`OSIO_D3_US), `OSIO_US2CYC(`OSIO_D4_US),
        `OSIO_US2CYC(`OSIO_D5_US), `OSIO_US2CYC(`OSIO_D6_US),
        `OSIO_US2CYC(`OSIO_D7_US)},
    parameter int unsigned INP_FILT_CYC = `OSIO_INP_FILT_CYC
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic ORIGIN_SENSOR,
    input wire logic ENCODER_INDEX,
    input wire logic IN_POSITION_INPUT,
    input wire logic PULSE_OUT,
    input wire logic START_REQ,
    input wire logic PULSE_DONE,
    input wire logic MOTOR_STOP,
    input wire logic IMM_STOP,
    input wire logic HOME_DONE,
    output logic START_GO,
    output logic INDEX_DONE,
    output logic ORIGIN_LATCH,
    output logic OPERATION_BUSY_OUTPUT,
    output logic DEVIATION_CLEAR_OUTPUT
);
    osio_state_type s;
    osio_state_type next_s;
    logic idx_f;
    logic inp_f;
    logic origin_on;
    logic inp_on;
    logic home_mode;
    logic idx_edge;
    logic wr;
    logic rd_cyc;
    logic clr_trig;
    logic clr_on;
    logic red_on;
    logic [2:0] width_code;
    logic [2:0] delay_code;
    logic [31:0] status;

    ////////////////////////////////////////////////////////////////////////
    // input filters

    osio_filter #(
        .LEN(`OSIO_INDEX_FILT_CYC)
    ) u_index_filter (
        .CLK_SYS(CLK_SYS),
        .RST(RST),
        .EN(s.env2[`OSIO_E2_IDX_FILTER]),
        .DIN(ENCODER_INDEX),
        .DOUT(idx_f)
    );

    osio_filter #(
        .LEN(INP_FILT_CYC)
    ) u_inp_filter (
        .CLK_SYS(CLK_SYS),
        .RST(RST),
        .EN(s.env1[`OSIO_E1_FILTER]),
        .DIN(IN_POSITION_INPUT),
        .DOUT(inp_f)
    );

    ////////////////////////////////////////////////////////////////////////
    // decoded conditions

    // input on when it equals the polarity bit
    assign origin_on = ~(ORIGIN_SENSOR ^ s.env1[`OSIO_E1_ORG_POL]);
    assign inp_on = ~(inp_f ^ s.env1[`OSIO_E1_INP_POL]);
    assign home_mode = (s.mode == `OSIO_MODE_HOME) ||
        (s.mode == `OSIO_MODE_HOME_LIM) ||
        (s.mode == `OSIO_MODE_AWAY);
    assign idx_edge = s.env2[`OSIO_E2_EDGE] ? (idx_f & ~s.idx_q) :
        (~idx_f & s.idx_q);
    // write lands at the edge where the master samples ack
    assign wr = WB_CYC_I & WB_STB_I & WB_WE_I & s.ack;
    assign rd_cyc = WB_CYC_I & WB_STB_I & ~s.ack;
    assign width_code = s.env1[`OSIO_E1_WIDTH_LO +: 3];
    assign delay_code = s.env1[`OSIO_E1_OFF_LO +: 3];
    assign clr_on = (s.cstate == OSIO_CLR_ON);
    assign red_on = (s.bstate == OSIO_BUSY_IDLE);

    always_comb begin
        clr_trig = 1'b0;
        if (s.env1[`OSIO_E1_CLR_ON_STOP] && IMM_STOP) begin
            clr_trig = 1'b1;
        end
        if (s.env1[`OSIO_E1_CLR_ON_HOME] && HOME_DONE) begin
            clr_trig = 1'b1;
        end
        if (wr && WB_ADR_I == `OSIO_ADR_CMD && WB_SEL_I[0] &&
            WB_DAT_I[7:0] == `OSIO_CMD_CLR_ON) begin
            clr_trig = 1'b1;
        end
    end

    always_comb begin
        status = '0;
        status[`OSIO_ST_BUSY] = s.busy;
        status[`OSIO_ST_ORG_LATCH] = s.org_latch;
        status[`OSIO_ST_INDEX] = idx_f;
        status[`OSIO_ST_ORIGIN] = origin_on;
        status[`OSIO_ST_INP] = inp_on;
        status[`OSIO_ST_CLEAR] = clr_on;
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_s = s;
        next_s.go = 1'b0;
        next_s.idx_done = 1'b0;
        next_s.pulse_q = PULSE_OUT;
        next_s.idx_q = idx_f;

        // bus slave: one-cycle ack, byte lanes honoured
        next_s.ack = rd_cyc;
        if (rd_cyc && !WB_WE_I) begin
            if (WB_ADR_I == `OSIO_ADR_MODE) begin
                next_s.rdata = '0;
                next_s.rdata[`OSIO_MD_MODE_LO +: 4] = s.mode;
                next_s.rdata[`OSIO_MD_WAIT_INP] = s.wait_inp;
            end else if (WB_ADR_I == `OSIO_ADR_ENV1) begin
                next_s.rdata = s.env1;
            end else if (WB_ADR_I == `OSIO_ADR_ENV2) begin
                next_s.rdata = s.env2;
            end else if (WB_ADR_I == `OSIO_ADR_STAT) begin
                next_s.rdata = status;
            end else begin
                next_s.rdata = '0;
            end
        end
        if (wr) begin
            if (WB_ADR_I == `OSIO_ADR_MODE) begin
                if (WB_SEL_I[0]) begin
                    next_s.mode = WB_DAT_I[`OSIO_MD_MODE_LO +: 4];
                end
                if (WB_SEL_I[1]) begin
                    next_s.wait_inp = WB_DAT_I[`OSIO_MD_WAIT_INP];
                end
            end else if (WB_ADR_I == `OSIO_ADR_ENV1) begin
                for (int i = 0; i < 4; i++) begin
                    if (WB_SEL_I[i]) begin
                        next_s.env1[i*8 +: 8] = WB_DAT_I[i*8 +: 8];
                    end
                end
            end else if (WB_ADR_I == `OSIO_ADR_ENV2) begin
                for (int i = 0; i < 4; i++) begin
                    if (WB_SEL_I[i]) begin
                        next_s.env2[i*8 +: 8] = WB_DAT_I[i*8 +: 8];
                    end
                end
            end
        end

        // origin latch: set wins over the stop clear
        if (MOTOR_STOP) begin
            next_s.org_latch = 1'b0;
            next_s.idx_cnt = '0;
        end
        if (home_mode && PULSE_OUT && !s.pulse_q && origin_on) begin
            next_s.org_latch = 1'b1;
        end

        // index count after origin found
        if (home_mode && s.org_latch && idx_edge && !MOTOR_STOP) begin
            if (s.idx_cnt == s.env2[`OSIO_E2_COUNT_LO +: 4]) begin
                next_s.idx_done = 1'b1;
                next_s.idx_cnt = '0;
            end else begin
                next_s.idx_cnt = s.idx_cnt + 4'h1;
            end
        end

        // start waits until clear pulse and off delay are over
        if (START_REQ) begin
            next_s.pend = 1'b1;
        end
        if ((s.pend || START_REQ) && s.cstate == OSIO_CLR_IDLE &&
            !clr_trig) begin
            next_s.pend = 1'b0;
            next_s.go = 1'b1;
        end

        // busy sequencing
        case (s.bstate)
            OSIO_BUSY_IDLE: begin
                if (s.go) begin
                    next_s.bstate = OSIO_BUSY_RUN;
                end
            end
            OSIO_BUSY_RUN: begin
                if (IMM_STOP) begin
                    next_s.bstate = OSIO_BUSY_IDLE;
                end else if (PULSE_DONE) begin
                    if (s.wait_inp && !inp_on) begin
                        next_s.bstate = OSIO_BUSY_WAIT;
                    end else begin
                        next_s.bstate = OSIO_BUSY_IDLE;
                    end
                end
            end
            OSIO_BUSY_WAIT: begin
                if (inp_on || IMM_STOP) begin
                    next_s.bstate = OSIO_BUSY_IDLE;
                end
            end
            default: begin
                next_s.bstate = OSIO_BUSY_IDLE;
            end
        endcase
        // one flop feeds both pin and status bit
        next_s.busy = (next_s.bstate != OSIO_BUSY_IDLE);

        // deviation clear timing
        case (s.cstate)
            OSIO_CLR_IDLE: begin
            end
            OSIO_CLR_ON: begin
                if (width_code != `OSIO_WIDTH_LEVEL) begin
                    if (s.tmr <= 25'h1) begin
                        next_s.cstate = OSIO_CLR_DELAY;
                        next_s.tmr = 25'(DELAY_CYC[delay_code]);
                    end else begin
                        next_s.tmr = s.tmr - 25'h1;
                    end
                end
            end
            OSIO_CLR_DELAY: begin
                if (s.tmr <= 25'h1) begin
                    next_s.cstate = OSIO_CLR_IDLE;
                    next_s.tmr = '0;
                end else begin
                    next_s.tmr = s.tmr - 25'h1;
                end
            end
            default: begin
                next_s.cstate = OSIO_CLR_IDLE;
            end
        endcase
        if (wr && WB_ADR_I == `OSIO_ADR_CMD && WB_SEL_I[0] &&
            WB_DAT_I[7:0] == `OSIO_CMD_CLR_OFF) begin
            next_s.cstate = OSIO_CLR_DELAY;
            next_s.tmr = 25'(DELAY_CYC[delay_code]);
        end
        if (clr_trig && !s.env1[`OSIO_E1_SHARED_SEL]) begin
            next_s.cstate = OSIO_CLR_ON;
            next_s.tmr = (width_code == `OSIO_WIDTH_LEVEL) ? 25'h0 :
                25'(WIDTH_CYC[width_code]);
        end

        // shared pin: active level equals the polarity bit
        if (s.env1[`OSIO_E1_SHARED_SEL]) begin
            next_s.pin = ~(red_on ^ s.env1[`OSIO_E1_CLR_POL]);
        end else begin
            next_s.pin = ~(clr_on ^ s.env1[`OSIO_E1_CLR_POL]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            s <= '0;
            s.pin <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign WB_DAT_O = s.rdata;
    assign WB_ACK_O = s.ack;
    assign START_GO = s.go;
    assign INDEX_DONE = s.idx_done;
    assign ORIGIN_LATCH = s.org_latch;
    assign OPERATION_BUSY_OUTPUT = s.busy;
    assign DEVIATION_CLEAR_OUTPUT = s.pin;
endmodule

/* File: inc/osio_cfg.svh */
// Purpose: offsets, field positions, codes and times of the origin/servo io
// Assumes: 25 MHz system clock
// Notes: times are in microseconds, counts derived from them
`ifndef OSIO_CFG_SVH
`define OSIO_CFG_SVH
`define OSIO_CLK_HZ 25000000
`define OSIO_US2CYC(us) ((us) * (`OSIO_CLK_HZ / 1000000))
`define OSIO_ADR_MODE 8'h00
`define OSIO_ADR_ENV1 8'h04
`define OSIO_ADR_ENV2 8'h08
`define OSIO_ADR_STAT 8'h0c
`define OSIO_ADR_CMD 8'h10
`define OSIO_CMD_CLR_ON 8'h10
`define OSIO_CMD_CLR_OFF 8'h11
`define OSIO_MODE_HOME 4'h1
`define OSIO_MODE_HOME_LIM 4'h2
`define OSIO_MODE_AWAY 4'h3
`define OSIO_MD_MODE_LO 0
`define OSIO_MD_WAIT_INP 9
`define OSIO_E1_ORG_POL 7
`define OSIO_E1_INP_POL 11
`define OSIO_E1_FILTER 12
`define OSIO_E1_WIDTH_LO 16
`define OSIO_E1_CLR_POL 19
`define OSIO_E1_OFF_LO 20
`define OSIO_E1_SHARED_SEL 23
`define OSIO_E1_CLR_ON_STOP 24
`define OSIO_E1_CLR_ON_HOME 25
`define OSIO_E2_EDGE 3
`define OSIO_E2_COUNT_LO 4
`define OSIO_E2_IDX_FILTER 10
`define OSIO_ST_BUSY 0
`define OSIO_ST_ORG_LATCH 1
`define OSIO_ST_INDEX 7
`define OSIO_ST_ORIGIN 21
`define OSIO_ST_INP 22
`define OSIO_ST_CLEAR 23
`define OSIO_WIDTH_LEVEL 3'h7
`define OSIO_INDEX_FILT_CYC 3
`define OSIO_INP_FILT_US 4
`define OSIO_INP_FILT_CYC `OSIO_US2CYC(`OSIO_INP_FILT_US)
`define OSIO_W0_US 12
`define OSIO_W1_US 102
`define OSIO_W2_US 409
`define OSIO_W3_US 1600
`define OSIO_W4_US 13000
`define OSIO_W5_US 52000
`define OSIO_W6_US 104000
`define OSIO_D1_US 12
`define OSIO_D2_US 1600
`define OSIO_D3_US 52000
`define OSIO_D4_US 104000
`define OSIO_D5_US 208000
`define OSIO_D6_US 416000
`define OSIO_D7_US 832000
`endif

/* File: inc/osio_pkg.sv */
// Purpose: types of the origin/servo io block
// Assumes: nothing
// Notes: widths of timers are fixed here
package osio_pkg;
    typedef enum logic [1:0] {
        OSIO_BUSY_IDLE = 2'b00,
        OSIO_BUSY_RUN = 2'b01,
        OSIO_BUSY_WAIT = 2'b10
    } osio_busy_type;
    typedef enum logic [1:0] {
        OSIO_CLR_IDLE = 2'b00,
        OSIO_CLR_ON = 2'b01,
        OSIO_CLR_DELAY = 2'b10
    } osio_clr_type;
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [3:0] mode;
        logic wait_inp;
        logic [31:0] env1;
        logic [31:0] env2;
        logic pulse_q;
        logic org_latch;
        logic [3:0] idx_cnt;
        logic idx_q;
        logic idx_done;
        osio_busy_type bstate;
        logic busy;
        logic pend;
        logic go;
        osio_clr_type cstate;
        logic [24:0] tmr;
        logic pin;
    } osio_state_type;
endpackage

/* File: logic/osio_filter.sv */
// Purpose: input glitch filter, level accepted after LEN stable cycles
// Assumes: input synchronous to CLK_SYS
// Notes: with EN low the input passes after one register
`timescale 1ns/100ps
module osio_filter #(
    parameter int unsigned LEN = 3
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic EN,
    input wire logic DIN,
    output logic DOUT
);
    localparam int CW = $clog2(LEN + 1);
    typedef struct packed {
        logic out;
        logic [CW-1:0] cnt;
    } osio_filt_type;
    osio_filt_type s;
    osio_filt_type next_s;

    always_comb begin
        next_s = s;
        if (!EN) begin
            next_s.out = DIN;
            next_s.cnt = '0;
        end else if (DIN == s.out) begin
            next_s.cnt = '0;
        end else if (s.cnt == CW'(LEN - 1)) begin
            next_s.out = DIN;
            next_s.cnt = '0;
        end else begin
            next_s.cnt = s.cnt + 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign DOUT = s.out;
endmodule

/* File: tb/osio_props.sv */
// Purpose: port assertions of osio_top
// Assumes: bound to every osio_top instance
// Notes: bus answer, pulse outputs and busy timing
`timescale 1ns/100ps
module osio_props (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    input wire logic PULSE_OUT,
    input wire logic MOTOR_STOP,
    input wire logic START_GO,
    input wire logic INDEX_DONE,
    input wire logic ORIGIN_LATCH,
    input wire logic OPERATION_BUSY_OUTPUT
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    wire logic req = WB_CYC_I && WB_STB_I;
    a_ack_answer: assert property (req && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not acknowledged");
    a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_ack_idle: assert property (!req |=> !WB_ACK_O)
        else $error("ack without request");
    a_go_pulse: assert property (START_GO |=> !START_GO)
        else $error("start pulse too long");
    a_busy_after_go: assert property (
        START_GO |=> OPERATION_BUSY_OUTPUT)
        else $error("busy not set after start");
    a_busy_rise_cause: assert property (
        $rose(OPERATION_BUSY_OUTPUT) |-> $past(START_GO))
        else $error("busy rose without start");
    a_index_pulse: assert property (INDEX_DONE |=> !INDEX_DONE)
        else $error("index done too long");
    a_latch_stop_clear: assert property (
        MOTOR_STOP && !PULSE_OUT && !$past(PULSE_OUT) |=> !ORIGIN_LATCH)
        else $error("origin latch kept after stop");
    c_go: cover property (START_GO);
    c_index: cover property (INDEX_DONE);
    c_latch: cover property ($rose(ORIGIN_LATCH));
endmodule
bind osio_top osio_props u_props (
    .CLK_SYS(CLK_SYS), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_ACK_O(WB_ACK_O), .PULSE_OUT(PULSE_OUT), .MOTOR_STOP(MOTOR_STOP),
    .START_GO(START_GO), .INDEX_DONE(INDEX_DONE),
    .ORIGIN_LATCH(ORIGIN_LATCH),
    .OPERATION_BUSY_OUTPUT(OPERATION_BUSY_OUTPUT));

/* File: tb/osio_partner.sv */
// Purpose: servo driver, origin sensor and index model
// Assumes: levels given as on/off by the bench
// Notes: in-position settles lag cycles after a settle pulse
`timescale 1ns/100ps
module osio_partner (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic org_pol,
    input wire logic inp_pol,
    input wire logic org_on,
    input wire logic idx_on,
    input wire logic settle,
    input wire logic [7:0] lag,
    output logic ORIGIN_SENSOR,
    output logic ENCODER_INDEX,
    output logic IN_POSITION_INPUT
);
    logic [7:0] cnt;
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST)
            cnt <= 8'h00;
        else if (settle)
            cnt <= lag;
        else if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
    end
    assign IN_POSITION_INPUT = (cnt != 8'h00) ? !inp_pol : inp_pol;
    assign ORIGIN_SENSOR = org_on ? org_pol : !org_pol;
    assign ENCODER_INDEX = idx_on;
endmodule

/* File: tb/origin_servo_signal_io_tb.sv */
// Purpose: self-checking bench of osio_top
// Assumes: short clear timers, filter of 4 cycles
// Notes: reads are checked by a queue watcher
`timescale 1ns/100ps
`include "osio_cfg.svh"
module origin_servo_signal_io_tb;
    localparam int unsigned WC [7] = '{4, 5, 6, 7, 8, 9, 10};
    localparam int unsigned DC [8] = '{0, 3, 5, 6, 7, 8, 9, 10};
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, pout = 0, c;
    logic [7:0] adr = 0, lag = 0;
    logic [31:0] wdat = 0, rdat;
    logic [4:0] ev = 0;
    logic opol = 0, ipol = 0, oon = 0, ion = 0, settle = 0;
    logic ack, origin_sensor, idx, inp, go, idone, olat, busy, clr;
    logic [63:0] q [$];
    int n_fail = 0, num_checks = 0, n_idx = 0, n, d, m;
    initial forever #20 clk = ~clk;
    osio_top #(.WIDTH_CYC(WC), .DELAY_CYC(DC), .INP_FILT_CYC(4)) dut (
        .CLK_SYS(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .ORIGIN_SENSOR(origin_sensor),
        .ENCODER_INDEX(idx), .IN_POSITION_INPUT(inp), .PULSE_OUT(pout),
        .START_REQ(ev[0]), .PULSE_DONE(ev[1]), .MOTOR_STOP(ev[2]),
        .IMM_STOP(ev[3]), .HOME_DONE(ev[4]), .START_GO(go),
        .INDEX_DONE(idone), .ORIGIN_LATCH(olat),
        .OPERATION_BUSY_OUTPUT(busy), .DEVIATION_CLEAR_OUTPUT(clr));
    osio_partner u_partner (.CLK_SYS(clk), .RST(rst), .org_pol(opol),
        .inp_pol(ipol), .org_on(oon), .idx_on(ion), .settle(settle),
        .lag(lag), .ORIGIN_SENSOR(origin_sensor), .ENCODER_INDEX(idx),
        .IN_POSITION_INPUT(inp));
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task print_verdict;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] v,
            input logic [31:0] mk);
        int k;
        @(posedge clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= v;
        if (!w)
            q.push_back({mk, v});
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1 && k < 50);
        if (ack === 1) begin
            cyc <= 0;
            stb <= 0;
        end else begin
            n_fail++;
            print_verdict;
        end
    endtask
    task fire(input int b);
        @(posedge clk);
        ev[b] <= 1;
        @(posedge clk);
        ev[b] <= 0;
    endtask
    task tick(input int t);
        repeat (t) @(posedge clk);
    endtask
    task inpos(input logic [7:0] l);
        @(posedge clk);
        lag <= l;
        settle <= 1;
        @(posedge clk);
        settle <= 0;
    endtask
    task wait_go;
        n = 0;
        while (go !== 1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk(n < 100, 1);
        if (n >= 100)
            print_verdict;
    endtask
    task ipulse(input int hi);
        @(posedge clk);
        ion <= 1;
        tick(hi);
        ion <= 0;
        tick(8);
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (idone === 1)
            n_idx++;
        if (ack === 1 && we === 0 && q.size() > 0) begin
            chk(rdat & q[0][63:32], q[0][31:0]);
            void'(q.pop_front());
        end
    end
    initial begin
        void'($urandom(43664));
        tick(2);
        rst <= 0;
        tick(1);
        chk(clr, 1);
        wb(0, 8'h14, 0, 32'hffffffff);
        for (int p = 0; p < 2; p++) begin
            opol <= p;
            ipol <= p;
            oon <= 1;
            ion <= 0;
            wb(1, `OSIO_ADR_ENV1, (p << 7) | (p << 11) | (p << 19), 0);
            tick(3);
            wb(0, `OSIO_ADR_STAT, 32'h00600000, 32'h00e00080);
            oon <= 0;
            ion <= 1;
            inpos(200);
            tick(3);
            wb(0, `OSIO_ADR_STAT, 32'h00000080, 32'h00e00080);
            inpos(0);
        end
        ion <= 0;
        ipol <= 0;
        for (int w = 0; w < 8; w++) begin
            c = $urandom;
            wb(1, `OSIO_ADR_ENV1, (c << 19) | (w << 16), 0);
            wb(1, `OSIO_ADR_CMD, `OSIO_CMD_CLR_ON, 0);
            n = 0;
            repeat (30) begin
                @(posedge clk);
                if (clr === c)
                    n++;
            end
            if (w < 7)
                chk(n, WC[w]);
            else begin
                wb(0, `OSIO_ADR_STAT, 32'h00800000, 32'h00800000);
                wb(1, `OSIO_ADR_CMD, `OSIO_CMD_CLR_OFF, 0);
                tick(3);
                chk(clr, !c);
            end
        end
        d = 1 + $urandom % 7;
        wb(1, `OSIO_ADR_ENV1, d << 20, 0);
        wb(1, `OSIO_ADR_CMD, `OSIO_CMD_CLR_ON, 0);
        fire(0);
        wait_go;
        chk(n >= WC[0] + DC[d], 1);
        fire(1);
        tick(2);
        chk(busy, 0);
        wb(1, `OSIO_ADR_MODE, 1 << 9, 0);
        fire(0);
        wait_go;
        chk(n <= 3, 1);
        inpos(30);
        fire(1);
        tick(5);
        chk(busy, 1);
        wb(0, `OSIO_ADR_STAT, 32'h1, 32'h1);
        n = 0;
        while (busy !== 0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk(n > 5 && n < 60, 1);
        if (n >= 100)
            print_verdict;
        fire(0);
        wait_go;
        tick(2);
        fire(1);
        tick(2);
        chk(busy, 0);
        wb(1, `OSIO_ADR_ENV1, 1 << 12, 0);
        fire(0);
        wait_go;
        inpos(3);
        fire(1);
        tick(2);
        chk(busy, 0);
        for (int i = 0; i < 4; i++) begin
            m = i[0] ? 24 + i[1] : 25 - i[1];
            wb(1, `OSIO_ADR_ENV1, (7 << 16) | (1 << m), 0);
            fire(3 + i[1]);
            tick(2);
            wb(0, `OSIO_ADR_STAT, i[0] << 23, 32'h00800000);
            wb(1, `OSIO_ADR_CMD, `OSIO_CMD_CLR_OFF, 0);
        end
        wb(1, `OSIO_ADR_ENV1, (1 << 23) | (1 << 19), 0);
        tick(2);
        chk(clr, 1);
        wb(1, `OSIO_ADR_CMD, `OSIO_CMD_CLR_ON, 0);
        wb(0, `OSIO_ADR_STAT, 0, 32'h00800000);
        opol <= 0;
        wb(1, `OSIO_ADR_ENV1, 0, 0);
        wb(1, `OSIO_ADR_MODE, 0, 0);
        oon <= 1;
        fire(2);
        pout <= 1;
        tick(3);
        chk(olat, 0);
        pout <= 0;
        wb(1, `OSIO_ADR_MODE, 1 + $urandom % 3, 0);
        pout <= 1;
        tick(3);
        chk(olat, 1);
        pout <= 0;
        oon <= 0;
        tick(3);
        chk(olat, 1);
        d = $urandom % 4;
        wb(1, `OSIO_ADR_ENV2, (d << 4) | 32'h408, 0);
        n_idx = 0;
        ipulse(2);
        chk(n_idx, 0);
        for (int i = 0; i < d; i++)
            ipulse(6);
        chk(n_idx, 0);
        @(posedge clk);
        ion <= 1;
        tick(7);
        chk(n_idx, 1);
        ion <= 0;
        fire(2);
        tick(2);
        chk(olat, 0);
        print_verdict;
    end
endmodule
